// ===== bench/tlic_bench.sv
`timescale 1ns/1ps
module tlic_bench;
    import tlic_pkg::*;
    logic                        clk, reset, nmi_pin, svc_evt, dbgmon_evt, tick_evt;
    logic                        core_halted, core_ack, core_ret, hold, took;
    logic [3:0]                  ext_pin, lat;
    logic [2:0]                  fault_evt;
    logic [5:0]                  core_ret_num, took_num, got[$];
    logic [31:0]                 rdata, m, c, bits;
    logic [NUM_PERIPH-1:0][15:0] src_evt;
    tlic_bus_t                   bus;
    tlic_req_t                   req;
    tlic_boot_fetch_t            boot;
    int                          fails, n_tests, cyc, i, p, s, pos, pr[33], q[$];

    tlic_top #(.SRC_W(16)) u_tlic_top (.clk, .reset, .bus, .rdata, .src_evt, .ext_pin,
        .nmi_pin, .fault_evt, .svc_evt, .dbgmon_evt, .tick_evt, .core_halted, .req,
        .core_ack, .core_ret, .core_ret_num, .boot);
    tlic_core_model u_tlic_core_model (.clk, .reset, .req, .lat, .hold, .core_ack,
        .core_ret, .core_ret_num, .took, .took_num);

    always #12.5 clk = ~clk;
    always @(posedge clk) if (took) got.push_back(took_num);
    always @(posedge clk) begin
        cyc++;
        if (cyc == 20000) begin
            fails++;
            $display("ERROR %0t: run limit reached", $time);
            close_out();
        end
    end

    // ----------------------------------------------------------------
    // Bus, event and compare tasks
    // ----------------------------------------------------------------
    task automatic chk(input logic [31:0] g, input logic [31:0] e);
        n_tests++;
        if (g !== e) begin
            fails++;
            $display("ERROR %0t: got %h expected %h", $time, g, e);
        end
    endtask
    task automatic wr(input logic [9:0] a, input logic [31:0] d);
        @(posedge clk);
        bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
        @(posedge clk);
        bus.wr <= 1'b0;
    endtask
    task automatic rd(input logic [9:0] a, input logic [31:0] e);
        @(posedge clk);
        bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
        @(posedge clk);
        bus.rd <= 1'b0;
        #1 chk(rdata, e);
    endtask
    // One source event, optionally in the same cycle as a write-one clear of its flag.
    task automatic ev(input int pp, input int ss, input logic clr);
        @(posedge clk);
        src_evt[pp][ss] <= 1'b1;
        bus <= '{wr: clr, rd: 1'b0, addr: 10'h300 + 10'(pp * 4), wdata: 32'(1) << ss};
        @(posedge clk);
        src_evt[pp][ss] <= 1'b0;
        bus.wr <= 1'b0;
    endtask
    task automatic hit(input logic [5:0] v);
        @(posedge clk);
        {fault_evt, svc_evt, dbgmon_evt, tick_evt} <= v;
        @(posedge clk);
        {fault_evt, svc_evt, dbgmon_evt, tick_evt} <= 6'h0;
    endtask
    task automatic take(input logic [5:0] e);
        for (int k = 0; k < 300 && got.size() == 0; k++) @(posedge clk);
        chk({26'h0, got.size() > 0 ? got.pop_front() : 6'h3f}, {26'h0, e});
    endtask
    task automatic none();
        repeat (12) @(posedge clk);
        chk(32'(got.size()), 32'h0);
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", n_tests, fails);
        if (fails == 0 && n_tests > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    initial begin
        {clk, reset, nmi_pin, svc_evt, dbgmon_evt, tick_evt, core_halted, hold} = 8'h40;
        {bus, src_evt, ext_pin, fault_evt, lat} = '0;
        void'($urandom(32'h6d4b54ed));
        repeat (16) @(posedge clk);
        reset <= 1'b0;
        m = $urandom & 32'h1ffff;
        c = $urandom & m;
        wr(10'h000, m);
        rd(10'h000, m);
        wr(10'h004, c);
        rd(10'h000, m & ~c);
        wr(10'h004, 32'h1ffff);
        rd(10'h0f0, 32'h0);
        wr(10'h108, 32'h1f);
        rd(10'h108, 32'h0);
        $display("test registers done");
        lat <= 4'($urandom % 4);
        bits = 0;
        while ($countones(bits) < 4) bits[$urandom % 17] = 1'b1;
        for (i = 0; i < 17; i++) if (bits[i]) begin
            pr[16 + i] = $urandom % 4;
            wr(10'h100 + 10'((16 + i) * 4), 32'(pr[16 + i]));
            q.push_back(16 + i);
        end
        wr(10'h008, bits);
        none();
        rd(10'h008, bits);
        q.sort() with (pr[item] * 64 + item);
        pos = q.pop_back();
        wr(10'h00c, 32'(1) << (pos - 16));
        bits[pos - 16] = 1'b0;
        rd(10'h008, bits);
        wr(10'h000, 32'h1ffff);
        foreach (q[k]) take(6'(q[k]));
        none();
        hold <= 1'b1;
        wr(10'h008, 32'h1);
        take(6'h10);
        wr(10'h010, 32'h1fffe);
        rd(10'h010, 32'h1);
        hold <= 1'b0;
        $display("test ordering done");
        p = $urandom % 12;
        s = $urandom % 16;
        ev(p, s, 1'b0);
        rd(10'h300 + 10'(p * 4), 32'(1) << s);
        none();
        hold <= 1'b1;
        wr(10'h200 + 10'(p * 4), 32'(1) << s);
        take(6'(16 + p));
        ev(p, s, 1'b1);
        rd(10'h300 + 10'(p * 4), 32'(1) << s);
        rd(10'h01c, 32'(1) << p);
        wr(10'h01c, 32'(1) << p);
        rd(10'h01c, 32'h0);
        wr(10'h300 + 10'(p * 4), 32'(1) << s);
        rd(10'h300 + 10'(p * 4), 32'h0);
        wr(10'h00c, 32'(1) << p);
        hold <= 1'b0;
        none();
        $display("test second level done");
        hold <= 1'b1;
        nmi_pin <= 1'b1;
        take(6'h02);
        nmi_pin <= 1'b0;
        wr(10'h008, 32'h2);
        none();
        hold <= 1'b0;
        take(6'h02);
        take(6'h11);
        for (i = 0; i < 3; i++) begin
            hit(6'h08 << i);
            take(6'h03);
        end
        repeat (8) @(posedge clk);
        none();
        hit(6'h04);
        take(6'h0b);
        hit(6'h01);
        take(6'h0f);
        core_halted <= 1'b1;
        wr(10'h014, 32'h8);
        hit(6'h02);
        none();
        core_halted <= 1'b0;
        hit(6'h02);
        take(6'h0c);
        wr(10'h018, 32'h1);
        take(6'h0e);
        ext_pin <= 4'h1;
        repeat (6) @(posedge clk);
        rd(10'h330, 32'h1);
        $display("test system done");
        close_out();
    end
endmodule

bind tlic_top tlic_chk #(.SRC_W(SRC_W)) u_chk (.clk, .reset, .bus, .rdata, .core_halted,
    .req, .core_ack, .core_ret, .core_ret_num, .boot);

// ===== bench/tlic_core_model.sv
`timescale 1ns/1ps
module tlic_core_model
    import tlic_pkg::*;
(
    input  wire logic                clk,
    input  wire logic                reset,
    input  wire tlic_pkg::tlic_req_t req,
    input  wire logic [3:0]          lat,
    input  wire logic                hold,
    output logic                     core_ack,
    output logic                     core_ret,
    output logic [5:0]               core_ret_num,
    output logic                     took,
    output logic [5:0]               took_num
);
    logic [5:0] stk[$];
    int         wt;
    int         rt;

    // Nested handlers return last-in first-out, as a real core unstacks.
    always @(posedge clk or posedge reset) begin
        if (reset) begin
            {core_ack, core_ret, took} <= 3'b0;
            core_ret_num <= 6'h0;
            took_num <= 6'h0;
            wt = 0;
            rt = 0;
            stk.delete();
        end else begin
            took <= core_ack && req.valid;
            took_num <= req.num;
            core_ret <= 1'b0;
            if (core_ack && req.valid) begin
                stk.push_back(req.num);
            end
            if (req.valid && !core_ack && wt >= lat) begin
                core_ack <= 1'b1;
                wt = 0;
            end else begin
                core_ack <= 1'b0;
                wt = req.valid ? wt + 1 : 0;
            end
            rt = (stk.size() > 0 && !hold) ? rt + 1 : 0;
            if (rt > 6 && !core_ack) begin
                core_ret <= 1'b1;
                core_ret_num <= stk.pop_back();
                rt = 0;
            end
        end
    end
endmodule

// ===== bench/tlic_top_asserts.sv
`timescale 1ns/1ps
module tlic_chk
    import tlic_pkg::*;
#(
    parameter int SRC_W = 16
) (
    input wire logic                       clk,
    input wire logic                       reset,
    input wire tlic_pkg::tlic_bus_t        bus,
    input wire logic [31:0]                rdata,
    input wire logic                       core_halted,
    input wire tlic_pkg::tlic_req_t        req,
    input wire logic                       core_ack,
    input wire logic                       core_ret,
    input wire logic [5:0]                 core_ret_num,
    input wire tlic_pkg::tlic_boot_fetch_t boot
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);

    // Tracks a serviced non-maskable entry; the ports alone do not show it.
    logic nmi_act_q;
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            nmi_act_q <= 1'b0;
        end else if (core_ack && req.valid && req.num == 6'h02) begin
            nmi_act_q <= 1'b1;
        end else if (core_ret && core_ret_num == 6'h02) begin
            nmi_act_q <= 1'b0;
        end
    end

    vec_addr_a: assert property (req.valid |-> req.vec_addr == {req.num, 2'b00})
        else $error("vector address does not follow position");
    req_pos_a: assert property (
        req.valid |-> req.num inside {[6'h02:6'h06], 6'h0b, 6'h0c, [6'h0e:6'h20]})
        else $error("offered position is not a real source");
    boot_order_a: assert property (
        boot.fetch && boot.vec_addr == 8'h00 |=> boot.fetch && boot.vec_addr == 8'h04)
        else $error("stack entry not followed by reset entry");
    boot_run_a: assert property (
        boot.fetch && boot.vec_addr == 8'h04 |=> !boot.fetch [*8])
        else $error("boot fetch did not end");
    boot_quiet_a: assert property (boot.fetch |-> !req.valid)
        else $error("request offered during boot");
    ack_clear_a: assert property (
        core_ack && req.valid |=> !(req.valid && req.num == $past(req.num)))
        else $error("taken exception offered again");
    nmi_hold_a: assert property (nmi_act_q |-> !req.valid)
        else $error("non-maskable handler preempted");
    dbg_halt_a: assert property (core_halted |-> !(req.valid && req.num == 6'h0c))
        else $error("debug monitor offered while halted");
    rd_idle_a: assert property (!$past(bus.rd) |-> rdata == 32'h0)
        else $error("read data outside its cycle");

    cover property (core_ack && req.valid && req.num >= 6'h10);
    cover property (req.valid && req.num == 6'h02);
    cover property (req.valid && req.num == 6'h03);
endmodule

// ===== core/tlic_cfg.svh
`ifndef TLIC_CFG_SVH
`define TLIC_CFG_SVH

// ----------------------------------------------------------------
// Register byte offsets
// ----------------------------------------------------------------
`define TLIC_OFS_EN_SET    10'h000
`define TLIC_OFS_EN_CLR    10'h004
`define TLIC_OFS_PEND_SET  10'h008
`define TLIC_OFS_PEND_CLR  10'h00c
`define TLIC_OFS_ACTIVE    10'h010
`define TLIC_OFS_SYS_EN    10'h014
`define TLIC_OFS_SYS_PEND  10'h018
`define TLIC_OFS_MISS      10'h01c
`define TLIC_OFS_PRIO_BASE 10'h100
`define TLIC_OFS_MASK_BASE 10'h200
`define TLIC_OFS_FLAG_BASE 10'h300

// ----------------------------------------------------------------
// Exception table positions
// ----------------------------------------------------------------
`define TLIC_POS_STACK    6'h00
`define TLIC_POS_RESET    6'h01
`define TLIC_POS_NMI      6'h02
`define TLIC_POS_HARD     6'h03
`define TLIC_POS_MEM      6'h04
`define TLIC_POS_BUS      6'h05
`define TLIC_POS_USAGE    6'h06
`define TLIC_POS_SVC      6'h0b
`define TLIC_POS_DBGMON   6'h0c
`define TLIC_POS_DEFER    6'h0e
`define TLIC_POS_TICK     6'h0f
`define TLIC_POS_PERIPH0  6'h10
`define TLIC_POS_LAST     6'h20
`define TLIC_POS_EXT_A    6'h1c

// ----------------------------------------------------------------
// System enable and pend field positions
// ----------------------------------------------------------------
`define TLIC_SYS_EN_MEM     0
`define TLIC_SYS_EN_BUS     1
`define TLIC_SYS_EN_USAGE   2
`define TLIC_SYS_EN_DBGMON  3
`define TLIC_SYS_PEND_SET   0
`define TLIC_SYS_PEND_CLR   1

// ----------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------
`define TLIC_RST_PRIO     5'h00
`define TLIC_RST_SYS_EN   4'h0
`define TLIC_THREAD_LEVEL 7'h40

`endif

// ===== core/tlic_pkg.sv
package tlic_pkg;

    localparam int NUM_POS    = 33;
    localparam int NUM_PERIPH = 17;

    typedef enum logic [2:0] {
        BOOT_SP  = 3'b001,
        BOOT_PC  = 3'b010,
        BOOT_RUN = 3'b100
    } tlic_boot_t;

    typedef struct packed {
        logic       valid;
        logic [5:0] num;
        logic [7:0] vec_addr;
    } tlic_req_t;

    typedef struct packed {
        logic       fetch;
        logic [7:0] vec_addr;
    } tlic_boot_fetch_t;

    typedef struct packed {
        logic       wr;
        logic       rd;
        logic [9:0] addr;
        logic [31:0] wdata;
    } tlic_bus_t;

endpackage

// ===== core/tlic_top.sv
// Design decisions made here: the plain strobed port and the register addresses.
`timescale 1ns/1ps
`include "tlic_cfg.svh"

module tlic_top #(
    parameter int SRC_W = 16
) (
    input  wire logic                          clk,
    input  wire logic                          reset,
    input  wire tlic_pkg::tlic_bus_t           bus,
    output logic [31:0]                        rdata,
    input  wire logic [tlic_pkg::NUM_PERIPH-1:0][SRC_W-1:0] src_evt,
    input  wire logic [3:0]                    ext_pin,
    input  wire logic                          nmi_pin,
    input  wire logic [2:0]                    fault_evt,
    input  wire logic                          svc_evt,
    input  wire logic                          dbgmon_evt,
    input  wire logic                          tick_evt,
    input  wire logic                          core_halted,
    output tlic_pkg::tlic_req_t                req,
    input  wire logic                          core_ack,
    input  wire logic                          core_ret,
    input  wire logic [5:0]                    core_ret_num,
    output tlic_pkg::tlic_boot_fetch_t         boot
);
    import tlic_pkg::*;

    localparam int NP = NUM_PERIPH;

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Effective urgency: the three fixed exceptions take codes below every
    // programmable code, so software can never outrank them.
    function automatic logic [6:0] eff(input logic [5:0] pos, input logic [4:0] pr);
        eff = (pos <= `TLIC_POS_HARD) ? {2'b00, pos[4:0]} : {2'b01, pr};
    endfunction

    function automatic logic in_bank(input logic [9:0] a, input logic [9:0] base);
        in_bank = (a[9:8] == base[9:8]);
    endfunction

    function automatic logic [31:0] pad17(input logic [NP-1:0] v);
        pad17 = {15'h0000, v};
    endfunction

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    logic [NUM_POS-1:0]          pend_q;
    logic [NUM_POS-1:0]          act_q;
    logic [NP-1:0]               en_q;
    logic [4:0]                  prio_q [NUM_POS];
    logic [3:0]                  sys_en_q;
    logic [NP-1:0][SRC_W-1:0]    mask_q;
    logic [NP-1:0][SRC_W-1:0]    flag_q;
    logic [NP-1:0]               miss_q;
    logic [3:0]                  pin_s1_q;
    logic [3:0]                  pin_s2_q;
    logic [3:0]                  pin_s3_q;
    logic                        nmi_s1_q;
    logic                        nmi_s2_q;
    tlic_boot_t                  boot_q;

    logic [NP-1:0][SRC_W-1:0]    evt;
    logic [NP-1:0]               line;
    logic [NUM_POS-1:0]          hw_set;
    logic [NUM_POS-1:0]          sw_set;
    logic [NUM_POS-1:0]          sw_clr;
    logic [NUM_POS-1:0]          eligible;
    logic [6:0]                  cur_eff;
    logic [6:0]                  best_eff;
    logic [5:0]                  best_pos;
    logic                        best_ok;
    logic                        wr_top;
    logic [5:0]                  widx;

    assign wr_top = bus.wr && (bus.addr[9:8] == 2'b00);
    assign widx   = bus.addr[7:2];

    // ------------------------------------------------------------
    // Pin synchronisers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pin_s1_q <= 4'h0;
            pin_s2_q <= 4'h0;
            pin_s3_q <= 4'h0;
            nmi_s1_q <= 1'b0;
            nmi_s2_q <= 1'b0;
        end else begin
            pin_s1_q <= ext_pin;
            pin_s2_q <= pin_s1_q;
            pin_s3_q <= pin_s2_q;
            nmi_s1_q <= nmi_pin;
            nmi_s2_q <= nmi_s1_q;
        end
    end

    // ------------------------------------------------------------
    // Second-level event merger
    // ------------------------------------------------------------
    // External pin lines feed source 0 of their peripheral on a rising edge.
    always_comb begin
        evt = src_evt;
        for (int k = 0; k < 4; k++) begin
            evt[int'(`TLIC_POS_EXT_A) - 16 + k][0] =
                src_evt[int'(`TLIC_POS_EXT_A) - 16 + k][0] | (pin_s2_q[k] & ~pin_s3_q[k]);
        end
        for (int p = 0; p < NP; p++) begin
            line[p] = |(flag_q[p] & mask_q[p]);
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            mask_q <= '0;
        end else if (bus.wr && in_bank(bus.addr, `TLIC_OFS_MASK_BASE) && widx < 6'(NP)) begin
            mask_q[widx] <= bus.wdata[SRC_W-1:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            flag_q <= '0;
        end else begin
            for (int p = 0; p < NP; p++) begin
                if (bus.wr && in_bank(bus.addr, `TLIC_OFS_FLAG_BASE) && widx == 6'(p)) begin
                    // The event term is ORed last so a clear never swallows it.
                    flag_q[p] <= (flag_q[p] & ~bus.wdata[SRC_W-1:0]) | evt[p];
                end else begin
                    flag_q[p] <= flag_q[p] | evt[p];
                end
            end
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            miss_q <= '0;
        end else begin
            for (int p = 0; p < NP; p++) begin
                if (|(evt[p] & flag_q[p] & mask_q[p])) begin
                    miss_q[p] <= 1'b1;
                end else if (bus.wr && bus.addr == `TLIC_OFS_MISS && bus.wdata[p]) begin
                    miss_q[p] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Arbitration
    // ------------------------------------------------------------
    always_comb begin
        cur_eff = `TLIC_THREAD_LEVEL;
        for (int i = 0; i < NUM_POS; i++) begin
            if (act_q[i] && eff(6'(i), prio_q[i]) < cur_eff) begin
                cur_eff = eff(6'(i), prio_q[i]);
            end
        end
    end

    always_comb begin
        eligible = pend_q;
        eligible[`TLIC_POS_MEM]    = pend_q[`TLIC_POS_MEM] & sys_en_q[`TLIC_SYS_EN_MEM];
        eligible[`TLIC_POS_BUS]    = pend_q[`TLIC_POS_BUS] & sys_en_q[`TLIC_SYS_EN_BUS];
        eligible[`TLIC_POS_USAGE]  = pend_q[`TLIC_POS_USAGE] & sys_en_q[`TLIC_SYS_EN_USAGE];
        eligible[`TLIC_POS_DBGMON] = pend_q[`TLIC_POS_DBGMON]
                                     & sys_en_q[`TLIC_SYS_EN_DBGMON] & ~core_halted;
        for (int p = 0; p < NP; p++) begin
            eligible[16 + p] = pend_q[16 + p] & en_q[p];
        end
        best_eff = `TLIC_THREAD_LEVEL;
        best_pos = 6'h00;
        best_ok  = 1'b0;
        // Scanning downward with <= lets the lower position win a tie.
        for (int i = NUM_POS - 1; i >= 0; i--) begin
            if (eligible[i] && eff(6'(i), prio_q[i]) <= best_eff) begin
                best_eff = eff(6'(i), prio_q[i]);
                best_pos = 6'(i);
                best_ok  = 1'b1;
            end
        end
    end

    // Strictly more urgent only: an active NMI is never preempted by itself.
    always_comb begin
        req.valid    = best_ok && (best_eff < cur_eff) && (boot_q == BOOT_RUN);
        req.num      = best_pos;
        req.vec_addr = {best_pos, 2'b00};
    end

    // ------------------------------------------------------------
    // Pending sources
    // ------------------------------------------------------------
    function automatic logic fault_ok(input logic [5:0] pos, input logic en, input logic [6:0] ce,
                                      input logic [4:0] pr);
        fault_ok = en && (eff(pos, pr) < ce);
    endfunction

    always_comb begin
        hw_set = '0;
        hw_set[`TLIC_POS_NMI] = nmi_s2_q;
        for (int f = 0; f < 3; f++) begin
            if (fault_evt[f]) begin
                if (fault_ok(`TLIC_POS_MEM + 6'(f), sys_en_q[f], cur_eff,
                             prio_q[int'(`TLIC_POS_MEM) + f])) begin
                    hw_set[int'(`TLIC_POS_MEM) + f] = 1'b1;
                end else begin
                    hw_set[`TLIC_POS_HARD] = 1'b1;
                end
            end
        end
        if (svc_evt) begin
            if (fault_ok(`TLIC_POS_SVC, 1'b1, cur_eff, prio_q[`TLIC_POS_SVC])) begin
                hw_set[`TLIC_POS_SVC] = 1'b1;
            end else begin
                hw_set[`TLIC_POS_HARD] = 1'b1;
            end
        end
        hw_set[`TLIC_POS_DBGMON] = dbgmon_evt && sys_en_q[`TLIC_SYS_EN_DBGMON] && !core_halted
            && (eff(`TLIC_POS_DBGMON, prio_q[`TLIC_POS_DBGMON]) < cur_eff);
        hw_set[`TLIC_POS_TICK] = tick_evt;
        for (int p = 0; p < NP; p++) begin
            hw_set[16 + p] = line[p];
        end
    end

    always_comb begin
        sw_set = '0;
        sw_clr = '0;
        if (wr_top && bus.addr == `TLIC_OFS_PEND_SET) begin
            sw_set[NUM_POS-1:16] = bus.wdata[NP-1:0];
        end
        if (wr_top && bus.addr == `TLIC_OFS_PEND_CLR) begin
            sw_clr[NUM_POS-1:16] = bus.wdata[NP-1:0];
        end
        if (wr_top && bus.addr == `TLIC_OFS_SYS_PEND) begin
            sw_set[`TLIC_POS_DEFER] = bus.wdata[`TLIC_SYS_PEND_SET];
            sw_clr[`TLIC_POS_DEFER] = bus.wdata[`TLIC_SYS_PEND_CLR];
        end
        if (core_ack && req.valid) begin
            sw_clr[best_pos] = 1'b1;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            pend_q <= '0;
        end else begin
            // A source asserting in a clearing cycle keeps its latch set.
            pend_q <= (pend_q & ~sw_clr) | hw_set | sw_set;
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            act_q <= '0;
        end else begin
            for (int i = 0; i < NUM_POS; i++) begin
                if (core_ack && req.valid && best_pos == 6'(i)) begin
                    act_q[i] <= 1'b1;
                end else if (core_ret && core_ret_num == 6'(i)) begin
                    act_q[i] <= 1'b0;
                end
            end
        end
    end

    // ------------------------------------------------------------
    // Configuration registers
    // ------------------------------------------------------------
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            en_q <= '0;
        end else if (wr_top && bus.addr == `TLIC_OFS_EN_SET) begin
            en_q <= en_q | bus.wdata[NP-1:0];
        end else if (wr_top && bus.addr == `TLIC_OFS_EN_CLR) begin
            en_q <= en_q & ~bus.wdata[NP-1:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            sys_en_q <= `TLIC_RST_SYS_EN;
        end else if (wr_top && bus.addr == `TLIC_OFS_SYS_EN) begin
            sys_en_q <= bus.wdata[3:0];
        end
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            for (int i = 0; i < NUM_POS; i++) begin
                prio_q[i] <= `TLIC_RST_PRIO;
            end
        end else if (bus.wr && in_bank(bus.addr, `TLIC_OFS_PRIO_BASE)
                     && widx > `TLIC_POS_HARD && widx <= `TLIC_POS_LAST) begin
            prio_q[widx] <= bus.wdata[4:0];
        end
    end

    // ------------------------------------------------------------
    // Boot sequence and read port
    // ------------------------------------------------------------
    // Stack value first, then the reset handler, then normal arbitration.
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            boot_q <= BOOT_SP;
        end else begin
            case (boot_q)
                BOOT_SP: boot_q <= BOOT_PC;
                BOOT_PC: boot_q <= BOOT_RUN;
                BOOT_RUN: boot_q <= BOOT_RUN;
                default: boot_q <= BOOT_SP;
            endcase
        end
    end

    always_comb begin
        boot.fetch    = (boot_q != BOOT_RUN);
        boot.vec_addr = (boot_q == BOOT_SP) ? {`TLIC_POS_STACK, 2'b00}
                                            : {`TLIC_POS_RESET, 2'b00};
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            rdata <= 32'h0000_0000;
        end else if (bus.rd) begin
            rdata <= 32'h0000_0000;
            case (bus.addr[9:8])
                2'b00: begin
                    case (bus.addr)
                        `TLIC_OFS_EN_SET, `TLIC_OFS_EN_CLR: rdata <= pad17(en_q);
                        `TLIC_OFS_PEND_SET, `TLIC_OFS_PEND_CLR: rdata <= pad17(pend_q[32:16]);
                        `TLIC_OFS_ACTIVE: rdata <= pad17(act_q[32:16]);
                        `TLIC_OFS_SYS_EN: rdata <= {28'h0000000, sys_en_q};
                        `TLIC_OFS_SYS_PEND: rdata <= {16'h0000, pend_q[15:0]};
                        `TLIC_OFS_MISS: rdata <= pad17(miss_q);
                        default: rdata <= 32'h0000_0000;
                    endcase
                end
                2'b01: if (widx <= `TLIC_POS_LAST) rdata <= {27'h0000000, prio_q[widx]};
                2'b10: if (widx < 6'(NP)) rdata <= 32'(mask_q[widx]);
                default: if (widx < 6'(NP)) rdata <= 32'(flag_q[widx]);
            endcase
        end else begin
            rdata <= 32'h0000_0000;
        end
    end

endmodule
